// ==== mcit_pkg.sv ====
// Package for the instruction decode and timing block.
// Assumes a single core clock and synchronous active-low reset.
package mcit_pkg;

  // Execution times in oscillator cycles.
  localparam logic [5:0] MCIT_CYC_SHORT = 6'd12;
  localparam logic [5:0] MCIT_CYC_LONG  = 6'd24;
  localparam logic [5:0] MCIT_CYC_MULDV = 6'd48;

  // Interrupt vectors, in within-level priority order 1 to 11.
  localparam int MCIT_NUM_IRQ = 11;
  localparam logic [7:0] MCIT_VEC_SUPPLY  = 8'h43;
  localparam logic [7:0] MCIT_VEC_WDOG    = 8'h5b;
  localparam logic [7:0] MCIT_VEC_EXT0    = 8'h03;
  localparam logic [7:0] MCIT_VEC_CONV    = 8'h33;
  localparam logic [7:0] MCIT_VEC_TMR0    = 8'h0b;
  localparam logic [7:0] MCIT_VEC_EXT1    = 8'h13;
  localparam logic [7:0] MCIT_VEC_TMR1    = 8'h1b;
  localparam logic [7:0] MCIT_VEC_SPI     = 8'h3b;
  localparam logic [7:0] MCIT_VEC_UART    = 8'h23;
  localparam logic [7:0] MCIT_VEC_TMR2    = 8'h2b;
  localparam logic [7:0] MCIT_VEC_INTERVAL = 8'h53;

  // Reset values.
  localparam logic [23:0] MCIT_RST_PTR = 24'h000000;
  localparam logic [15:0] MCIT_RST_PC  = 16'h0000;
  localparam logic [7:0]  MCIT_RST_ACC = 8'h00;

  // Field positions.
  localparam int MCIT_PAGE_LSB = 11;
  localparam int MCIT_SEL_RI   = 0;

  // Operation classes delivered by the decoder.
  typedef enum logic [4:0] {
    MCIT_OP_NOP    = 5'h00,
    MCIT_OP_ADD    = 5'h01,
    MCIT_OP_ADD_WITH_CARRY   = 5'h02,
    MCIT_OP_SUBTRACT_WITH_BORROW   = 5'h03,
    MCIT_OP_INCPTR = 5'h04,
    MCIT_OP_MUL    = 5'h05,
    MCIT_OP_DIV    = 5'h06,
    MCIT_OP_MOVACC = 5'h07,
    MCIT_OP_MOVMEM = 5'h08,
    MCIT_OP_LDPTR  = 5'h09,
    MCIT_OP_CODEP  = 5'h0a,
    MCIT_OP_CODEA  = 5'h0b,
    MCIT_OP_XRD    = 5'h0c,
    MCIT_OP_XWR    = 5'h0d,
    MCIT_OP_CBNE   = 5'h0e,
    MCIT_OP_DBNZ   = 5'h0f,
    MCIT_OP_AJMP   = 5'h10,
    MCIT_OP_ACALL  = 5'h11,
    MCIT_OP_SJMP   = 5'h12,
    MCIT_OP_BITSET = 5'h13,
    MCIT_OP_BITLOG = 5'h14,
    MCIT_OP_OTHER  = 5'h1f
  } mcit_op_e;

  // Operand addressing forms.
  typedef enum logic [2:0] {
    MCIT_AM_NONE = 3'h0,
    MCIT_AM_ACC  = 3'h1,
    MCIT_AM_REG  = 3'h2,
    MCIT_AM_DIR  = 3'h3,
    MCIT_AM_IND  = 3'h4,
    MCIT_AM_IMM  = 3'h5,
    MCIT_AM_PTR  = 3'h6
  } mcit_am_e;

  // Sequencer states, Gray coded along fetch, execute, done.
  typedef enum logic [1:0] {
    MCIT_ST_IDLE = 2'b00,
    MCIT_ST_EXEC = 2'b01,
    MCIT_ST_DONE = 2'b11
  } mcit_st_e;

endpackage

// ==== mcit_decode.sv ====
// Opcode decoder: class, length, timing and operand forms.
// Assumes a standard 8-bit accumulator core opcode map.
`timescale 1ns/1ps
module mcit_decode
  import mcit_pkg::*;
(
  // Opcode in.
  input  wire logic [7:0] opcode_i,
  // Decode out.
  output mcit_op_e        op_o,
  output logic [1:0]      len_o,
  output logic [5:0]      cyc_o,
  output mcit_am_e        src_o,
  output mcit_am_e        dst_o,
  output logic [2:0]      reg_sel_o
);
  import mcit_pkg::*;

  logic [3:0] lo;
  logic [3:0] hi;
  logic       rn;

  always_comb begin
    lo = opcode_i[3:0];
    hi = opcode_i[7:4];
    rn = opcode_i[3];
    op_o = MCIT_OP_OTHER;
    len_o = 2'd1;
    cyc_o = MCIT_CYC_SHORT;
    src_o = MCIT_AM_NONE;
    dst_o = MCIT_AM_NONE;
    reg_sel_o = rn ? opcode_i[2:0] : {2'b00, opcode_i[0]};
    if (opcode_i == 8'h00) begin
      op_o = MCIT_OP_NOP;
    end else if (lo == 4'h1) begin
      op_o = hi[0] ? MCIT_OP_ACALL : MCIT_OP_AJMP;
      len_o = 2'd2;
      cyc_o = MCIT_CYC_LONG;
    end else if (opcode_i == 8'h80) begin
      op_o = MCIT_OP_SJMP;
      len_o = 2'd2;
      cyc_o = MCIT_CYC_LONG;
    end else if (opcode_i == 8'ha3) begin
      op_o = MCIT_OP_INCPTR;
      cyc_o = MCIT_CYC_LONG;
    end else if (opcode_i == 8'ha4 || opcode_i == 8'h84) begin
      op_o = (opcode_i == 8'ha4) ? MCIT_OP_MUL : MCIT_OP_DIV;
      cyc_o = MCIT_CYC_MULDV;
    end else if (opcode_i == 8'h90) begin
      op_o = MCIT_OP_LDPTR;
      len_o = 2'd3;
      cyc_o = MCIT_CYC_LONG;
      src_o = MCIT_AM_IMM;
      dst_o = MCIT_AM_PTR;
    end else if (opcode_i == 8'h93 || opcode_i == 8'h83) begin
      op_o = (opcode_i == 8'h93) ? MCIT_OP_CODEP : MCIT_OP_CODEA;
      cyc_o = MCIT_CYC_LONG;
      dst_o = MCIT_AM_ACC;
    end else if (hi == 4'he && (lo == 4'h0 || lo == 4'h2 || lo == 4'h3)) begin
      op_o = MCIT_OP_XRD;
      cyc_o = MCIT_CYC_LONG;
      src_o = (lo == 4'h0) ? MCIT_AM_PTR : MCIT_AM_IND;
      dst_o = MCIT_AM_ACC;
    end else if (hi == 4'hf && (lo == 4'h0 || lo == 4'h2 || lo == 4'h3)) begin
      op_o = MCIT_OP_XWR;
      cyc_o = MCIT_CYC_LONG;
      src_o = MCIT_AM_ACC;
      dst_o = (lo == 4'h0) ? MCIT_AM_PTR : MCIT_AM_IND;
    end else if (hi == 4'hb && lo >= 4'h4) begin
      op_o = MCIT_OP_CBNE;
      len_o = 2'd3;
      cyc_o = MCIT_CYC_LONG;
      src_o = (lo == 4'h5) ? MCIT_AM_DIR : MCIT_AM_IMM;
      dst_o = (lo < 4'h6) ? MCIT_AM_ACC : (rn ? MCIT_AM_REG : MCIT_AM_IND);
    end else if (hi == 4'hd && (lo == 4'h5 || rn)) begin
      op_o = MCIT_OP_DBNZ;
      len_o = rn ? 2'd2 : 2'd3;
      cyc_o = MCIT_CYC_LONG;
      dst_o = rn ? MCIT_AM_REG : MCIT_AM_DIR;
    end else if ((hi == 4'h2 || hi == 4'h3 || hi == 4'h9) && lo >= 4'h4) begin
      op_o = (hi == 4'h2) ? MCIT_OP_ADD : ((hi == 4'h3) ? MCIT_OP_ADD_WITH_CARRY : MCIT_OP_SUBTRACT_WITH_BORROW);
      len_o = (lo == 4'h4 || lo == 4'h5) ? 2'd2 : 2'd1;
      dst_o = MCIT_AM_ACC;
      src_o = (lo == 4'h4) ? MCIT_AM_IMM : ((lo == 4'h5) ? MCIT_AM_DIR
            : (rn ? MCIT_AM_REG : MCIT_AM_IND));
    end else if (hi == 4'h8 && lo >= 4'h5) begin
      op_o = MCIT_OP_MOVMEM;
      cyc_o = MCIT_CYC_LONG;
      len_o = (lo == 4'h5) ? 2'd3 : 2'd2;
      src_o = (lo == 4'h5) ? MCIT_AM_DIR : (rn ? MCIT_AM_REG : MCIT_AM_IND);
      dst_o = MCIT_AM_DIR;
    end else if ((hi == 4'he || hi == 4'hf) && lo >= 4'h5) begin
      op_o = MCIT_OP_MOVACC;
      len_o = (lo == 4'h5) ? 2'd2 : 2'd1;
      src_o = hi[0] ? MCIT_AM_ACC : (lo == 4'h5 ? MCIT_AM_DIR : (rn ? MCIT_AM_REG : MCIT_AM_IND));
      dst_o = hi[0] ? (lo == 4'h5 ? MCIT_AM_DIR : (rn ? MCIT_AM_REG : MCIT_AM_IND)) : MCIT_AM_ACC;
    end else if ((hi == 4'hc || hi == 4'hd || hi == 4'hb) && lo == 4'h2) begin
      op_o = MCIT_OP_BITSET;
      len_o = 2'd2;
      src_o = MCIT_AM_DIR;
    end else if ((hi == 4'h8 || hi == 4'h7 || hi == 4'ha || hi == 4'hb) && lo == 4'h0) begin
      op_o = MCIT_OP_BITLOG;
      len_o = 2'd2;
      cyc_o = MCIT_CYC_LONG;
      src_o = MCIT_AM_DIR;
    end
  end

endmodule

// ==== mcit_irq_pick.sv ====
// Fixed-priority interrupt picker with vector lookup.
// Assumes request flags are already on the core clock.
`timescale 1ns/1ps
module mcit_irq_pick
  import mcit_pkg::*;
#(
  parameter int N = MCIT_NUM_IRQ
) (
  // Requests, bit 0 highest priority.
  input  wire logic [N-1:0] req_i,
  // Winner.
  output logic              any_o,
  output logic [7:0]        vec_o
);
  import mcit_pkg::*;

  localparam logic [7:0] VEC [11] = '{MCIT_VEC_SUPPLY, MCIT_VEC_WDOG, MCIT_VEC_EXT0,
    MCIT_VEC_CONV, MCIT_VEC_TMR0, MCIT_VEC_EXT1, MCIT_VEC_TMR1, MCIT_VEC_SPI,
    MCIT_VEC_UART, MCIT_VEC_TMR2, MCIT_VEC_INTERVAL};

  always_comb begin
    any_o = 1'b0;
    vec_o = 8'h00;
    for (int i = N - 1; i >= 0; i--) begin
      if (req_i[i]) begin
        any_o = 1'b1;
        vec_o = VEC[i];
      end
    end
  end

endmodule

// ==== mcit_core_timing.sv ====
// Instruction sequencer: fetch, timed execute, pointer and branch math, dispatch.
// Assumes program memory answers a fetch within the same cycle it is asked.
//
// Behaviour
// - Add, carry-add, borrow-subtract take 12 cycles.
// - Pointer increment carries across all 24 bits.
// - Multiply and divide are one byte, 48 cycles.
// - Memory moves 24 cycles, accumulator moves 12.
// - Code read address is accumulator plus base.
// - External access via R0/R1 or pointer, 24.
// - Compare-branch-unequal is three bytes, 24 cycles.
// - Decrement, branch if nonzero; 24 cycles.
// - Page-local target replaces low 11 PC bits.
// - Direct source operand is full 8-bit address.
// - Indirect pointer is R0 or R1 only.
// - Working register selects R0 through R7.
// - Wide immediate pointer load: three bytes, 24.
// - Bit ops by 8-bit address; 12 or 24.
// - Supply monitor vectors 43h, highest priority.
// - Converter ready flags vector 33h, priority 4.
// - Interval counter vectors 53h, lowest priority.
`timescale 1ns/1ps
module mcit_core_timing
  import mcit_pkg::*;
(
  // Clock and reset.
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  // Instruction bytes from program memory.
  input  wire logic        instr_valid_i,
  input  wire logic [7:0]  instr_b0_i,
  input  wire logic [7:0]  instr_b1_i,
  input  wire logic [7:0]  instr_b2_i,
  // Operand state from the core.
  input  wire logic [7:0]  acc_i,
  input  wire logic [7:0]  operand_i,
  input  wire logic [7:0]  reg_val_i,
  input  wire logic [1:0]  bank_i,
  // Interrupt sources, already synchronous.
  input  wire logic        supply_monitor_irq_flag_i,
  input  wire logic        watchdog_irq_flag_i,
  input  wire logic        ext0_irq_i,
  input  wire logic [1:0]  converter_ready_flags_i,
  input  wire logic        tmr0_irq_i,
  input  wire logic        ext1_irq_i,
  input  wire logic        tmr1_irq_i,
  input  wire logic        spi_irq_i,
  input  wire logic        uart_irq_i,
  input  wire logic        tmr2_irq_i,
  input  wire logic        interval_irq_flag_i,
  // Sequencer status.
  output logic             busy_o,
  output logic             done_o,
  output mcit_op_e         op_o,
  output logic [1:0]       len_o,
  output logic [5:0]       cycles_o,
  output logic [15:0]      pc_o,
  output logic [23:0]      data_pointer_o,
  // Operand addressing.
  output logic [7:0]       int_addr_o,
  output logic             int_addr_valid_o,
  // Code and external memory strobes.
  output logic [23:0]      code_addr_o,
  output logic             code_rd_o,
  output logic [23:0]      xaddr_o,
  output logic             xrd_o,
  output logic             xwr_o,
  // Interrupt dispatch.
  output logic             irq_take_o,
  output logic [7:0]       irq_vec_o
);
  import mcit_pkg::*;

  typedef struct packed {
    mcit_st_e    st;
    logic        busy;
    mcit_op_e    op;
    logic [1:0]  len;
    logic [5:0]  cyc;
    logic [5:0]  cnt;
    logic [15:0] pc;
    logic [23:0] data_pointer;
    logic [7:0]  iaddr;
    logic        iaddr_v;
    logic [23:0] caddr;
    logic        crd;
    logic [23:0] xaddr;
    logic        xrd;
    logic        xwr;
    logic        itake;
    logic [7:0]  ivec;
    logic        done;
  } mcit_state_s;

  mcit_state_s state_ff;
  mcit_state_s nxt_state;

  mcit_op_e   dec_op;
  logic [1:0] dec_len;
  logic [5:0] dec_cyc;
  mcit_am_e   dec_src;
  mcit_am_e   dec_dst;
  logic [2:0] dec_reg;
  logic       irq_any;
  logic [7:0] irq_vec;
  logic [MCIT_NUM_IRQ-1:0] irq_req;

  mcit_decode u_decode (
    .opcode_i  (instr_b0_i),
    .op_o      (dec_op),
    .len_o     (dec_len),
    .cyc_o     (dec_cyc),
    .src_o     (dec_src),
    .dst_o     (dec_dst),
    .reg_sel_o (dec_reg)
  );

  assign irq_req = {interval_irq_flag_i, tmr2_irq_i, uart_irq_i, spi_irq_i, tmr1_irq_i,
                    ext1_irq_i, tmr0_irq_i, |converter_ready_flags_i, ext0_irq_i,
                    watchdog_irq_flag_i, supply_monitor_irq_flag_i};

  mcit_irq_pick #(
    .N (MCIT_NUM_IRQ)
  ) u_irq_pick (
    .req_i (irq_req),
    .any_o (irq_any),
    .vec_o (irq_vec)
  );

  logic [15:0] pc_next;
  logic [15:0] rel_tgt;
  logic [7:0]  rel_off;
  logic [7:0]  dec_res;
  logic [7:0]  cmp_val;

  always_comb begin
    nxt_state = state_ff;
    nxt_state.done = 1'b0;
    nxt_state.crd = 1'b0;
    nxt_state.xrd = 1'b0;
    nxt_state.xwr = 1'b0;
    nxt_state.itake = 1'b0;
    nxt_state.iaddr_v = 1'b0;
    pc_next = state_ff.pc + {14'h0000, dec_len};
    rel_off = (dec_op == MCIT_OP_SJMP || dec_op == MCIT_OP_DBNZ && dec_len == 2'd2)
              ? instr_b1_i : instr_b2_i;
    rel_tgt = pc_next + {{8{rel_off[7]}}, rel_off};
    dec_res = ((dec_dst == MCIT_AM_REG) ? reg_val_i : operand_i) - 8'h01;
    cmp_val = (dec_src == MCIT_AM_IMM) ? instr_b1_i : operand_i;
    case (state_ff.st)
      MCIT_ST_IDLE: begin
        if (irq_any) begin
          nxt_state.itake = 1'b1;
          nxt_state.ivec = irq_vec;
          nxt_state.pc = {8'h00, irq_vec};
        end else if (instr_valid_i) begin
          nxt_state.st = MCIT_ST_EXEC;
          nxt_state.op = dec_op;
          nxt_state.len = dec_len;
          nxt_state.cyc = dec_cyc;
          nxt_state.cnt = 6'd1;
          nxt_state.pc = pc_next;
          if (dec_src == MCIT_AM_DIR) begin
            nxt_state.iaddr = instr_b1_i;
            nxt_state.iaddr_v = 1'b1;
          end else if (dec_src == MCIT_AM_IND || dec_dst == MCIT_AM_IND
                       || dec_src == MCIT_AM_REG || dec_dst == MCIT_AM_REG) begin
            nxt_state.iaddr = {3'b000, bank_i, dec_reg};
            nxt_state.iaddr_v = 1'b1;
          end
          case (dec_op)
            MCIT_OP_INCPTR: nxt_state.data_pointer = state_ff.data_pointer + 24'h000001;
            MCIT_OP_LDPTR: nxt_state.data_pointer = {state_ff.data_pointer[23:16], instr_b1_i, instr_b2_i};
            MCIT_OP_CODEP: begin
              nxt_state.caddr = state_ff.data_pointer + {16'h0000, acc_i};
              nxt_state.crd = 1'b1;
            end
            MCIT_OP_CODEA: begin
              nxt_state.caddr = {8'h00, pc_next + {8'h00, acc_i}};
              nxt_state.crd = 1'b1;
            end
            MCIT_OP_XRD, MCIT_OP_XWR: begin
              nxt_state.xaddr = (dec_src == MCIT_AM_PTR || dec_dst == MCIT_AM_PTR)
                                ? state_ff.data_pointer : {16'h0000, reg_val_i};
              nxt_state.xrd = (dec_op == MCIT_OP_XRD);
              nxt_state.xwr = (dec_op == MCIT_OP_XWR);
            end
            MCIT_OP_AJMP, MCIT_OP_ACALL: begin
              nxt_state.pc = {pc_next[15:MCIT_PAGE_LSB], instr_b0_i[7:5], instr_b1_i};
            end
            MCIT_OP_SJMP: nxt_state.pc = rel_tgt;
            MCIT_OP_CBNE: begin
              if (((dec_dst == MCIT_AM_ACC) ? acc_i : reg_val_i) != cmp_val) begin
                nxt_state.pc = rel_tgt;
              end
            end
            MCIT_OP_DBNZ: begin
              if (dec_res != 8'h00) begin
                nxt_state.pc = rel_tgt;
              end
            end
            default: begin
            end
          endcase
        end
      end
      MCIT_ST_EXEC: begin
        nxt_state.cnt = state_ff.cnt + 6'd1;
        if (state_ff.cnt >= state_ff.cyc - 6'd1) begin
          nxt_state.st = MCIT_ST_DONE;
        end
      end
      MCIT_ST_DONE: begin
        nxt_state.done = 1'b1;
        nxt_state.st = MCIT_ST_IDLE;
      end
      default: begin
        nxt_state.st = MCIT_ST_IDLE;
      end
    endcase
    nxt_state.busy = (nxt_state.st != MCIT_ST_IDLE);
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      state_ff <= '{st: MCIT_ST_IDLE, op: MCIT_OP_NOP, pc: MCIT_RST_PC, data_pointer: MCIT_RST_PTR,
                    default: '0};
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign busy_o = state_ff.busy;
  assign done_o = state_ff.done;
  assign op_o = state_ff.op;
  assign len_o = state_ff.len;
  assign cycles_o = state_ff.cyc;
  assign pc_o = state_ff.pc;
  assign data_pointer_o = state_ff.data_pointer;
  assign int_addr_o = state_ff.iaddr;
  assign int_addr_valid_o = state_ff.iaddr_v;
  assign code_addr_o = state_ff.caddr;
  assign code_rd_o = state_ff.crd;
  assign xaddr_o = state_ff.xaddr;
  assign xrd_o = state_ff.xrd;
  assign xwr_o = state_ff.xwr;
  assign irq_take_o = state_ff.itake;
  assign irq_vec_o = state_ff.ivec;

endmodule

// ==== mcit_core_timing_asserts.sv ====
// Port checker for the sequencer: timing, pointer, branch and dispatch.
// Assumes it is bound to the sequencer top and sees only its ports.
`timescale 1ns/1ps
module mcit_core_timing_chk (
  // Clock, reset and fetch.
  input wire logic        ref_clk_i,
  input wire logic        rst_n_i,
  input wire logic        instr_valid_i,
  input wire logic [7:0]  instr_b0_i,
  input wire logic [7:0]  instr_b1_i,
  input wire logic [7:0]  acc_i,
  // Interrupt requests.
  input wire logic        supply_monitor_irq_flag_i,
  input wire logic        watchdog_irq_flag_i,
  input wire logic        ext0_irq_i,
  input wire logic [1:0]  converter_ready_flags_i,
  input wire logic        tmr0_irq_i,
  input wire logic        ext1_irq_i,
  input wire logic        tmr1_irq_i,
  input wire logic        spi_irq_i,
  input wire logic        uart_irq_i,
  input wire logic        tmr2_irq_i,
  input wire logic        interval_irq_flag_i,
  // Sequencer outputs.
  input wire logic        busy_o,
  input wire logic        done_o,
  input wire logic [1:0]  len_o,
  input wire logic [5:0]  cycles_o,
  input wire logic [15:0] pc_o,
  input wire logic [23:0] data_pointer_o,
  input wire logic [7:0]  int_addr_o,
  input wire logic        int_addr_valid_o,
  input wire logic [23:0] code_addr_o,
  input wire logic        code_rd_o,
  input wire logic [23:0] xaddr_o,
  input wire logic        xrd_o,
  input wire logic        irq_take_o,
  input wire logic [7:0]  irq_vec_o
);
  logic [10:0] req;
  logic        take;
  logic [15:0] nx_pc;
  logic [15:0] pg_tgt;
  logic [15:0] rel_tgt;

  always_comb begin
    req = {interval_irq_flag_i, tmr2_irq_i, uart_irq_i, spi_irq_i, tmr1_irq_i, ext1_irq_i,
           tmr0_irq_i, |converter_ready_flags_i, ext0_irq_i, watchdog_irq_flag_i,
           supply_monitor_irq_flag_i};
    take = !busy_o && instr_valid_i && (req == 11'h000);
    nx_pc = pc_o + 16'h0002;
    pg_tgt = {nx_pc[15:11], instr_b0_i[7:5], instr_b1_i};
    rel_tgt = nx_pc + {{8{instr_b1_i[7]}}, instr_b1_i};
  end

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_tk(logic [7:0] code);
    take && instr_b0_i == code;
  endsequence

  AST_ADD_WITH_CARRY: assert property (s_tk(8'h34) |-> ##1 (len_o == 2'h2) ##12 done_o)
    else $error("carry add timing wrong");
  AST_INCP: assert property (s_tk(8'ha3) |-> ##25
    (done_o && data_pointer_o == $past(data_pointer_o, 25) + 24'h000001))
    else $error("pointer increment wrong");
  AST_MUL: assert property (s_tk(8'ha4) |-> ##1 (cycles_o == 6'h30) ##48 done_o)
    else $error("multiply timing wrong");
  AST_MOVE: assert property (s_tk(8'h85) |-> ##1 (len_o == 2'h3) ##24 done_o)
    else $error("memory move timing wrong");
  AST_XRD: assert property (s_tk(8'he0) |-> ##[1:2] (xrd_o && xaddr_o == data_pointer_o))
    else $error("external read address wrong");
  AST_CODE: assert property (s_tk(8'h93) |=> code_rd_o
    && code_addr_o == $past(data_pointer_o) + {16'h0000, $past(acc_i)})
    else $error("code read address wrong");
  AST_DIR: assert property (s_tk(8'he5) |=> int_addr_valid_o
    && int_addr_o == $past(instr_b1_i))
    else $error("direct address wrong");
  AST_PAGE: assert property (take && instr_b0_i[3:0] == 4'h1 |=> pc_o == $past(pg_tgt))
    else $error("page local target wrong");
  AST_REL: assert property (s_tk(8'h80) |=> pc_o == $past(rel_tgt))
    else $error("relative target wrong");
  AST_SUPPLY: assert property (!busy_o && req[0] |=> irq_take_o && irq_vec_o == 8'h43)
    else $error("supply monitor dispatch wrong");
  AST_CONV: assert property (!busy_o && req[3:0] == 4'h8 |=> irq_vec_o == 8'h33)
    else $error("converter dispatch wrong");
endmodule

// ==== mcit_prog_mem.sv ====
// Program memory and external data memory model facing the sequencer.
// Assumes the bench fills mem before it raises ask_i.
`timescale 1ns/1ps
module mcit_prog_mem (
  // Clock and fetch side.
  input  wire logic        ref_clk_i,
  input  wire logic        ask_i,
  input  wire logic [15:0] pc_i,
  output logic             valid_o,
  output logic [7:0]       b0_o,
  output logic [7:0]       b1_o,
  output logic [7:0]       b2_o,
  // External data side.
  input  wire logic        xrd_i,
  input  wire logic        xwr_i,
  input  wire logic [23:0] xaddr_i,
  output logic [23:0]      xlast_o
);
  logic [7:0]  mem [4096];
  logic [11:0] a;

  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
  end

  // Bytes are offered only while asked; otherwise their inverse, so stale bytes never match.
  always_comb begin
    a = pc_i[11:0];
    valid_o = ask_i;
    b0_o = ask_i ? mem[a] : ~mem[a];
    b1_o = ask_i ? mem[a + 12'h001] : ~mem[a + 12'h001];
    b2_o = ask_i ? mem[a + 12'h002] : ~mem[a + 12'h002];
  end

  // Each one-cycle strobe is one external access at the address it carries.
  always @(posedge ref_clk_i) begin
    if (xrd_i || xwr_i) begin
      xlast_o <= xaddr_i;
    end
  end
endmodule

// ==== mcit_core_timing_tb.sv ====
// Self-checking bench for the instruction sequencer.
// Assumes the program memory model and the bound port checker.
`timescale 1ns/1ps
module mcit_core_timing_tb;
  import mcit_pkg::*;
  typedef struct packed {
    logic [7:0] b0;
    logic [7:0] b1;
    logic [1:0] len;
    logic [5:0] cyc;
  } mcit_row_s;
  // Opcode, second byte, length and cycles; branch offsets are zero.
  mcit_row_s rows [18] = '{
    '{8'h24, 8'h01, 2'h2, 6'h0c}, '{8'h34, 8'h02, 2'h2, 6'h0c},
    '{8'h94, 8'h03, 2'h2, 6'h0c}, '{8'ha3, 8'h00, 2'h1, 6'h18},
    '{8'ha4, 8'h00, 2'h1, 6'h30}, '{8'h84, 8'h00, 2'h1, 6'h30},
    '{8'he8, 8'h00, 2'h1, 6'h0c}, '{8'h85, 8'h30, 2'h3, 6'h18},
    '{8'h90, 8'h12, 2'h3, 6'h18}, '{8'h93, 8'h00, 2'h1, 6'h18},
    '{8'h83, 8'h00, 2'h1, 6'h18}, '{8'he0, 8'h00, 2'h1, 6'h18},
    '{8'hf0, 8'h00, 2'h1, 6'h18}, '{8'hb4, 8'h07, 2'h3, 6'h18},
    '{8'hd8, 8'h00, 2'h2, 6'h18}, '{8'hd5, 8'h40, 2'h3, 6'h18},
    '{8'hd2, 8'h20, 2'h2, 6'h0c}, '{8'hb0, 8'h20, 2'h2, 6'h18}
  };
  logic [7:0]  vec_t [11] = '{8'h43, 8'h5b, 8'h03, 8'h33, 8'h0b, 8'h13, 8'h1b, 8'h3b,
                              8'h23, 8'h2b, 8'h53};
  logic        ref_clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        ask = 1'b0;
  logic        cv_hi = 1'b0;
  logic [10:0] irq = 11'h000;
  logic [7:0]  acc_i = 8'h00;
  logic [7:0]  operand_i = 8'h00;
  logic [7:0]  reg_val_i = 8'h00;
  logic [1:0]  bank_i = 2'h0;
  logic [7:0]  instr_b0_i, instr_b1_i, instr_b2_i, irq_vec_o, int_addr_o;
  logic        instr_valid_i, busy_o, done_o, int_addr_valid_o, code_rd_o, xrd_o, xwr_o;
  logic        irq_take_o;
  mcit_op_e    op_o;
  logic [1:0]  len_o;
  logic [5:0]  cycles_o;
  logic [15:0] pc_o, exp_pc;
  logic [23:0] data_pointer_o, code_addr_o, xaddr_o, xlast;
  int          err_count = 0;
  int          comparisons = 0;
  int          ticks = 0;
  int          n;

  mcit_core_timing mcit_core_timing_i (
    .ref_clk_i, .rst_n_i, .instr_valid_i, .instr_b0_i, .instr_b1_i, .instr_b2_i,
    .acc_i, .operand_i, .reg_val_i, .bank_i,
    .supply_monitor_irq_flag_i(irq[0]), .watchdog_irq_flag_i(irq[1]), .ext0_irq_i(irq[2]),
    .converter_ready_flags_i({cv_hi, irq[3]}), .tmr0_irq_i(irq[4]), .ext1_irq_i(irq[5]),
    .tmr1_irq_i(irq[6]), .spi_irq_i(irq[7]), .uart_irq_i(irq[8]), .tmr2_irq_i(irq[9]),
    .interval_irq_flag_i(irq[10]), .busy_o, .done_o, .op_o, .len_o, .cycles_o, .pc_o,
    .data_pointer_o, .int_addr_o, .int_addr_valid_o, .code_addr_o, .code_rd_o, .xaddr_o,
    .xrd_o, .xwr_o, .irq_take_o, .irq_vec_o
  );

  mcit_prog_mem mcit_prog_mem_i (
    .ref_clk_i, .ask_i(ask), .pc_i(pc_o), .valid_o(instr_valid_i), .b0_o(instr_b0_i),
    .b1_o(instr_b1_i), .b2_o(instr_b2_i), .xrd_i(xrd_o), .xwr_i(xwr_o), .xaddr_i(xaddr_o),
    .xlast_o(xlast)
  );

  always #5 ref_clk_i = ~ref_clk_i;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("Errors %0d of %0d comparisons", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Places one instruction at the current counter, offers it once, waits for done.
  task automatic run(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2);
    mcit_prog_mem_i.mem[pc_o[11:0]] = b0;
    mcit_prog_mem_i.mem[pc_o[11:0] + 12'h001] = b1;
    mcit_prog_mem_i.mem[pc_o[11:0] + 12'h002] = b2;
    ask <= 1'b1;
    @(posedge ref_clk_i);
    ask <= 1'b0;
    n = 0;
    while (done_o !== 1'b1 && n < 60) begin
      @(posedge ref_clk_i);
      n++;
    end
  endtask

  task automatic do_reset();
    rst_n_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    check(32'(pc_o), 32'h0);
    check(32'(data_pointer_o), 32'h0);
    check(32'(busy_o), 32'h0);
  endtask

  always @(posedge ref_clk_i) begin
    ticks++;
    if (ticks == 5000) begin
      err_count++;
      wrap_up();
    end
  end

  initial begin
    do_reset();
    exp_pc = 16'h0000;
    foreach (rows[i]) begin
      run(rows[i].b0, rows[i].b1, 8'h00);
      exp_pc += 16'(rows[i].len);
      check(n, 32'(rows[i].cyc) + 32'h1);
      check(32'(cycles_o), 32'(rows[i].cyc));
      check(32'(len_o), 32'(rows[i].len));
      check(32'(pc_o), 32'(exp_pc));
    end
    run(8'h90, 8'hff, 8'hff);
    check(32'(data_pointer_o), 32'h00ffff);
    run(8'ha3, 8'h00, 8'h00);
    check(32'(data_pointer_o), 32'h010000);
    acc_i <= 8'h05;
    run(8'h93, 8'h00, 8'h00);
    check(32'(code_addr_o), 32'h010005);
    check(32'(op_o), 32'(MCIT_OP_CODEP));
    run(8'he0, 8'h00, 8'h00);
    check(32'(xlast), 32'h010000);
    reg_val_i <= 8'h5a;
    run(8'hf3, 8'h00, 8'h00);
    check(32'(xlast), 32'h5a);
    bank_i <= 2'h2;
    run(8'hef, 8'h00, 8'h00);
    check(32'(int_addr_o), 32'h17);
    run(8'he5, 8'hff, 8'h00);
    check(32'(int_addr_o), 32'hff);
    run(8'he1, 8'hfe, 8'h00);
    check(32'(pc_o), 32'h07fe);
    run(8'h24, 8'h00, 8'h00);
    run(8'h21, 8'h23, 8'h00);
    check(32'(pc_o), 32'h0923);
    run(8'h80, 8'hfe, 8'h00);
    check(32'(pc_o), 32'h0923);
    run(8'h80, 8'h10, 8'h00);
    check(32'(pc_o), 32'h0935);
    run(8'hb4, 8'h05, 8'h10);
    check(32'(pc_o), 32'h0938);
    run(8'hb4, 8'h06, 8'h10);
    check(32'(pc_o), 32'h094b);
    run(8'hd8, 8'h02, 8'h00);
    check(32'(pc_o), 32'h094f);
    reg_val_i <= 8'h01;
    run(8'hd8, 8'h02, 8'h00);
    check(32'(pc_o), 32'h0951);
    for (int k = 10; k >= 0; k--) begin
      irq <= 11'h7ff << k;
      repeat (2) @(posedge ref_clk_i);
      check(32'(irq_vec_o), 32'(vec_t[k]));
      check(32'(irq_take_o), 32'h1);
    end
    ask <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    check(32'(busy_o), 32'h0);
    check(32'(pc_o), 32'h0043);
    ask <= 1'b0;
    irq <= 11'h000;
    cv_hi <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    check(32'(irq_vec_o), 32'h33);
    cv_hi <= 1'b0;
    do_reset();
    wrap_up();
  end
endmodule

bind mcit_core_timing mcit_core_timing_chk mcit_core_timing_chk_i (
  .ref_clk_i, .rst_n_i, .instr_valid_i, .instr_b0_i, .instr_b1_i, .acc_i,
  .supply_monitor_irq_flag_i, .watchdog_irq_flag_i, .ext0_irq_i, .converter_ready_flags_i,
  .tmr0_irq_i, .ext1_irq_i, .tmr1_irq_i, .spi_irq_i, .uart_irq_i, .tmr2_irq_i,
  .interval_irq_flag_i, .busy_o, .done_o, .len_o, .cycles_o, .pc_o, .data_pointer_o,
  .int_addr_o, .int_addr_valid_o, .code_addr_o, .code_rd_o,
  .xaddr_o, .xrd_o, .irq_take_o, .irq_vec_o
);
